//--- logic/pms_defs.svh
// timing constants and pin bit positions for the mac-side receive status pins
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ------------------------------------------------------------
// system clock
// ------------------------------------------------------------
`define PMS_CLK_NS 20

// ------------------------------------------------------------
// receive clock half periods, in ns as printed rates imply
// ------------------------------------------------------------
// 2.5 MHz -> 400 ns period
`define PMS_RXCLK_HALF_NS_10M 200
// 25 MHz -> 40 ns period
`define PMS_RXCLK_HALF_NS_100M 20
// 125 MHz -> 8 ns period
`define PMS_RXCLK_HALF_NS_1G 4

// half time rounds down to whole cycles, never below one cycle
`define PMS_HALF_CYC(ns) ((((ns) / `PMS_CLK_NS) < 1) ? 1 : ((ns) / `PMS_CLK_NS))

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMS_DATA_HI_MSB 7
`define PMS_DATA_HI_LSB 4
`define PMS_PIN_LOW 1'b0
`define PMS_NIBBLE_ZERO 4'h0
`define PMS_CNT_ZERO 8'h00
`define PMS_CNT_ONE 8'h01

`endif

//--- logic/pms_pkg.sv
// types shared by the mac-side receive status pin block
`default_nettype none

package pms_pkg;

	// mac interface mode, one-hot
	typedef enum logic [2:0]
	{
		PMS_MII = 3'h1,
		PMS_GMII = 3'h2,
		PMS_RGMII = 3'h4
	} pms_mode_type;

	// line speed, one-hot
	typedef enum logic [2:0]
	{
		PMS_SPD_10 = 3'h1,
		PMS_SPD_100 = 3'h2,
		PMS_SPD_1000 = 3'h4
	} pms_speed_type;

	// one receive beat offered by the receive datapath
	typedef struct packed
	{
		logic valid;
		logic error;
		logic carrier;
		logic [7:0] data;
	} pms_rx_symbol_type;

	// one transmit beat as taken from the mac
	typedef struct packed
	{
		logic enable;
		logic error;
	} pms_tx_beat_type;

	// transmit control sampler states
	typedef enum logic [1:0]
	{
		PMS_TXS_RISE = 2'h1,
		PMS_TXS_FALL = 2'h2
	} pms_txs_type;

endpackage : pms_pkg

`default_nettype wire

//--- logic/pms_sync.sv
// two-flop synchroniser with edge detection for mac-driven pins
`default_nettype none
`timescale 1ns/1ns

module pms_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// asynchronous pins
	input wire logic [W-1:0] async_in,
	// synchronised levels and edges
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges look only at the second and third stage
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;

endmodule : pms_sync

`default_nettype wire

//--- logic/pms_clk_div.sv
// divider making the link clock level and its edge enables
`default_nettype none
`timescale 1ns/1ns
`include "pms_defs.svh"

module pms_clk_div (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// half period in system cycles
	input wire logic [7:0] half_cycles,
	// link clock and its edges
	output logic clk_level,
	output logic rise_en,
	output logic fall_en
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic level_q;
	logic tick;

	assign tick = (cnt_q >= (half_cycles - `PMS_CNT_ONE));
	assign cnt_d = tick ? `PMS_CNT_ZERO : cnt_q + `PMS_CNT_ONE;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= `PMS_CNT_ZERO;
			level_q <= `PMS_PIN_LOW;
		end
		else
		begin
			cnt_q <= cnt_d;
			level_q <= tick ? ~level_q : level_q;
		end
	end

	// enables mark the cycle before the pin level changes
	assign clk_level = level_q;
	assign rise_en = tick & ~level_q;
	assign fall_en = tick & level_q;

endmodule : pms_clk_div

`default_nettype wire

//--- logic/pms_rx_status_pins.sv
// mac-side receive status pins of an ethernet phy: clocks, upper data, control
//
// How it works
// [RQ1] gmii drives receive data bits four-seven
// [RQ2] mac raises transmit enable for data
// [RQ3] rgmii transmit control carries enable and error
// [RQ4] receive valid marks valid nibble or byte
// [RQ5] rgmii receive control muxes valid and error
// [RQ6] receive error high on detected error
// [RQ7] rgmii leaves separate receive error unused
// [RQ8] half duplex collision on simultaneous activity
// [RQ9] mac synchronises the asynchronous collision pin
// [RQ10] full duplex holds collision low
// [RQ11] rgmii leaves collision unused
// [RQ12] half duplex carrier on receive or transmit
// [RQ13] 10/100 full duplex carrier on receive
// [RQ14] gigabit full duplex carrier is undefined
// [RQ15] rgmii leaves carrier sense unused
// [RQ16] mac supplies continuous 125 MHz transmit clock; the bench mac gives 6.25 MHz, sampled at 50 MHz
// [RQ17] receive clock 2.5, 25, 125 MHz; gigabit gives 25 MHz here
// [RQ18] mii transmit clock driven at 2.5/25 MHz
// [RQ19] transmit error substitutes invalid symbols
// [RQ20] rising sample enable, falling sample enable xor error
`default_nettype none
`timescale 1ns/1ns
`include "pms_defs.svh"

module pms_rx_status_pins (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// configuration, same clock domain
	input wire pms_pkg::pms_mode_type mode,
	input wire pms_pkg::pms_speed_type speed,
	input wire logic full_duplex,
	// receive beats from the datapath
	input wire pms_pkg::pms_rx_symbol_type rx_symbol,
	output logic rx_take,
	// transmit beats toward the datapath
	output pms_pkg::pms_tx_beat_type tx_beat,
	output logic tx_beat_strobe,
	output logic tx_send_invalid,
	// pins from the mac
	input wire logic gtx_clk,
	input wire logic tx_en_ctrl,
	input wire logic tx_er,
	// clock pins toward the mac
	output logic rx_clk,
	output logic tx_clk,
	// receive pins toward the mac
	output logic receive_data_bit_four,
	output logic receive_data_bit_five,
	output logic receive_data_bit_six,
	output logic receive_data_bit_seven,
	output logic receive_valid_error_combined,
	output logic rx_er,
	output logic col,
	output logic crs
);

	import pms_pkg::*;

	// ------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------

	function automatic logic [7:0] half_for_speed(input pms_speed_type s);
		logic [7:0] h;
		h = 8'(`PMS_HALF_CYC(`PMS_RXCLK_HALF_NS_1G));
		unique case (s)
			PMS_SPD_10: h = 8'(`PMS_HALF_CYC(`PMS_RXCLK_HALF_NS_10M));
			PMS_SPD_100: h = 8'(`PMS_HALF_CYC(`PMS_RXCLK_HALF_NS_100M));
			PMS_SPD_1000: h = 8'(`PMS_HALF_CYC(`PMS_RXCLK_HALF_NS_1G));
			default: h = 8'(`PMS_HALF_CYC(`PMS_RXCLK_HALF_NS_1G));
		endcase
		return h;
	endfunction : half_for_speed

	logic is_mii;
	logic is_gmii;
	logic is_rgmii;
	logic is_gig;
	logic half_duplex;
	logic [7:0] half_cycles;

	assign is_mii = (mode == PMS_MII);
	assign is_gmii = (mode == PMS_GMII);
	assign is_rgmii = (mode == PMS_RGMII);
	assign is_gig = (speed == PMS_SPD_1000);
	assign half_duplex = ~full_duplex;
	assign half_cycles = half_for_speed(speed);

	// ------------------------------------------------------------
	// link clock generation
	// ------------------------------------------------------------

	logic link_level;
	logic link_rise;
	logic link_fall;

	// [RQ17] recovered clock rate
	pms_clk_div u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.half_cycles(half_cycles),
		.clk_level(link_level),
		.rise_en(link_rise),
		.fall_en(link_fall)
	);

	logic tx_clk_q;
	logic tx_clk_d;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tx_clk_q <= `PMS_PIN_LOW;
		else
			tx_clk_q <= tx_clk_d;
	end

	// [RQ18] mii transmit clock
	assign tx_clk_d = is_mii & (link_rise ? 1'b1 : (link_fall ? 1'b0 : tx_clk_q));

	// gigabit needs 125 MHz; at 50 MHz the fastest pin is 25 MHz
	assign rx_clk = link_level;
	assign tx_clk = tx_clk_q;

	// ------------------------------------------------------------
	// receive pins
	// ------------------------------------------------------------

	logic [3:0] rx_hi_q;
	logic rx_ctrl_q;
	logic rx_er_q;
	logic rx_dv_hold_q;
	logic rx_err_hold_q;

	// beat is taken on the receive clock rising edge
	assign rx_take = link_rise;

	logic [3:0] rx_hi_d;
	logic rx_ctrl_rise_d;
	logic rx_ctrl_fall_d;
	logic rx_er_d;

	// [RQ1] upper nibble only in gmii
	assign rx_hi_d = is_gmii ?
		rx_symbol.data[`PMS_DATA_HI_MSB:`PMS_DATA_HI_LSB] : `PMS_NIBBLE_ZERO;

	// [RQ4] valid with nibble or byte
	assign rx_ctrl_rise_d = rx_symbol.valid;

	// [RQ20] falling half is valid xor error
	assign rx_ctrl_fall_d = rx_dv_hold_q ^ rx_err_hold_q;

	// [RQ6] error pin tracks detected error
	// [RQ7] silent in rgmii
	assign rx_er_d = ~is_rgmii & rx_symbol.error;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_hi_q <= `PMS_NIBBLE_ZERO;
			rx_ctrl_q <= `PMS_PIN_LOW;
			rx_er_q <= `PMS_PIN_LOW;
			rx_dv_hold_q <= `PMS_PIN_LOW;
			rx_err_hold_q <= `PMS_PIN_LOW;
		end
		else if (link_rise)
		begin
			rx_hi_q <= rx_hi_d;
			rx_ctrl_q <= rx_ctrl_rise_d;
			rx_er_q <= rx_er_d;
			rx_dv_hold_q <= rx_symbol.valid;
			rx_err_hold_q <= rx_symbol.error;
		end
		// [RQ5] second half on falling edge
		else if (link_fall && is_rgmii)
		begin
			rx_ctrl_q <= rx_ctrl_fall_d;
		end
	end

	assign receive_data_bit_four = rx_hi_q[0];
	assign receive_data_bit_five = rx_hi_q[1];
	assign receive_data_bit_six = rx_hi_q[2];
	assign receive_data_bit_seven = rx_hi_q[3];
	assign receive_valid_error_combined = rx_ctrl_q;
	assign rx_er = rx_er_q;

	// ------------------------------------------------------------
	// transmit pin sampling
	// ------------------------------------------------------------

	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	// mac pins cross into clk_sys through two flops
	pms_sync #(
		.W(3)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({tx_er, tx_en_ctrl, gtx_clk}),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	logic s_en;
	logic s_er;
	logic gtx_rise;
	logic gtx_fall;
	logic tx_rise_ev;

	assign s_en = pin_level[1];
	assign s_er = pin_level[2];
	assign gtx_rise = pin_rise[0];
	assign gtx_fall = pin_fall[0];

	// [RQ16] gmii/rgmii clocked by mac, mii by own clock
	assign tx_rise_ev = is_mii ? link_rise : gtx_rise;

	pms_txs_type txs_q;
	pms_txs_type txs_d;
	logic rise_bit_q;
	logic rise_bit_d;
	pms_tx_beat_type beat_q;
	pms_tx_beat_type beat_d;
	logic strobe_q;
	logic strobe_d;

	always_comb
	begin
		txs_d = txs_q;
		rise_bit_d = rise_bit_q;
		beat_d = beat_q;
		strobe_d = 1'b0;
		unique case (txs_q)
			PMS_TXS_RISE:
			begin
				if (tx_rise_ev && is_rgmii)
				begin
					rise_bit_d = s_en;
					txs_d = PMS_TXS_FALL;
				end
				// [RQ2] enable marks data present
				else if (tx_rise_ev)
				begin
					beat_d.enable = s_en;
					beat_d.error = s_er;
					strobe_d = 1'b1;
				end
			end
			PMS_TXS_FALL:
			begin
				if (!is_rgmii)
					txs_d = PMS_TXS_RISE;
				// [RQ3] one line, both edges
				// [RQ20] error is rise xor fall
				else if (gtx_fall)
				begin
					beat_d.enable = rise_bit_q;
					beat_d.error = rise_bit_q ^ s_en;
					strobe_d = 1'b1;
					txs_d = PMS_TXS_RISE;
				end
			end
			default:
				txs_d = PMS_TXS_RISE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txs_q <= PMS_TXS_RISE;
			rise_bit_q <= `PMS_PIN_LOW;
			beat_q <= '0;
			strobe_q <= `PMS_PIN_LOW;
		end
		else
		begin
			txs_q <= txs_d;
			rise_bit_q <= rise_bit_d;
			beat_q <= beat_d;
			strobe_q <= strobe_d;
		end
	end

	assign tx_beat = beat_q;
	assign tx_beat_strobe = strobe_q;

	// [RQ19] error replaces data with invalid symbols
	assign tx_send_invalid = beat_q.error;

	// ------------------------------------------------------------
	// collision and carrier sense
	// ------------------------------------------------------------

	logic tx_active;
	logic rx_active;
	logic col_d;
	logic crs_d;
	logic col_q;
	logic crs_q;

	assign tx_active = beat_q.enable;
	assign rx_active = rx_symbol.carrier;

	// [RQ8] simultaneous activity in half duplex
	// [RQ10] low in full duplex
	// [RQ11] unused in rgmii
	assign col_d = ~is_rgmii & half_duplex & tx_active & rx_active;

	// [RQ12] half duplex: either direction
	// [RQ13] 10/100 full duplex: receive only
	// [RQ14] gigabit full duplex held low
	// [RQ15] unused in rgmii
	assign crs_d = is_rgmii ? `PMS_PIN_LOW :
		half_duplex ? (tx_active | rx_active) :
		is_gig ? `PMS_PIN_LOW : rx_active;

	// [RQ9] collision is free of the link clocks; mac must resync
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			col_q <= `PMS_PIN_LOW;
			crs_q <= `PMS_PIN_LOW;
		end
		else
		begin
			col_q <= col_d;
			crs_q <= crs_d;
		end
	end

	assign col = col_q;
	assign crs = crs_q;

endmodule : pms_rx_status_pins

`default_nettype wire

//--- tb/pms_rx_status_pins_checker.sv
// assertion checker for the mac-side receive status pins
`timescale 1ns/1ns
`default_nettype none
module pms_rx_status_pins_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// configuration and beats
	input wire pms_pkg::pms_mode_type mode,
	input wire pms_pkg::pms_speed_type speed,
	input wire logic full_duplex,
	input wire pms_pkg::pms_rx_symbol_type rx_symbol,
	input wire logic rx_take,
	input wire pms_pkg::pms_tx_beat_type tx_beat,
	input wire logic tx_beat_strobe,
	input wire logic tx_send_invalid,
	// pins toward the mac
	input wire logic rx_clk,
	input wire logic tx_clk,
	input wire logic receive_data_bit_four,
	input wire logic receive_data_bit_seven,
	input wire logic receive_valid_error_combined,
	input wire logic rx_er,
	input wire logic col,
	input wire logic crs
);
import pms_pkg::*;
wire logic rgm;
wire logic gmii;
wire logic hdx;
logic v_q;
logic e_q;
assign rgm = (mode == PMS_RGMII);
assign gmii = (mode == PMS_GMII);
assign hdx = !rgm && !full_duplex;
// beat kept for the low receive clock phase
always_ff @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		v_q <= 1'b0;
		e_q <= 1'b0;
	end
	else if (rx_take)
	begin
		v_q <= rx_symbol.valid;
		e_q <= rx_symbol.error;
	end
end
// --------
// properties
// --------
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!rst_n);
property p_hi;
	rx_take |=> receive_data_bit_four == (gmii && $past(rx_symbol.data[4]))
		&& receive_data_bit_seven == (gmii && $past(rx_symbol.data[7]));
endproperty
a_hi: assert property (p_hi) else $error("upper data bits wrong");
property p_dv;
	rx_take && !rgm |=> receive_valid_error_combined == $past(rx_symbol.valid)
		&& rx_er == $past(rx_symbol.error);
endproperty
a_dv: assert property (p_dv) else $error("valid or error pin wrong");
property p_per;
	rx_take |=> $rose(rx_clk) and (if (speed == PMS_SPD_10) ##19 rx_take else ##1 rx_take);
endproperty
a_per: assert property (p_per) else $error("receive clock period wrong");
property p_rgh;
	rgm && $rose(rx_clk) |-> receive_valid_error_combined == v_q;
endproperty
a_rgh: assert property (p_rgh) else $error("high phase control wrong");
property p_rgl;
	rgm && $fell(rx_clk) |-> receive_valid_error_combined == (v_q ^ e_q);
endproperty
a_rgl: assert property (p_rgl) else $error("low phase control wrong");
property p_rgu;
	rgm |-> !rx_er && !col && !crs;
endproperty
a_rgu: assert property (p_rgu) else $error("unused pin driven");
property p_col;
	hdx |=> col == $past(tx_beat.enable && rx_symbol.carrier);
endproperty
a_col: assert property (p_col) else $error("collision wrong");
property p_fcol;
	full_duplex |-> !col;
endproperty
a_fcol: assert property (p_fcol) else $error("collision in full duplex");
property p_hcrs;
	hdx |=> crs == $past(tx_beat.enable || rx_symbol.carrier);
endproperty
a_hcrs: assert property (p_hcrs) else $error("half duplex carrier wrong");
property p_fcrs;
	!rgm && full_duplex && speed != PMS_SPD_1000 |=> crs == $past(rx_symbol.carrier);
endproperty
a_fcrs: assert property (p_fcrs) else $error("full duplex carrier wrong");
property p_txc;
	mode != PMS_MII |-> !tx_clk;
endproperty
a_txc: assert property (p_txc) else $error("transmit clock outside mii");
property p_inv;
	tx_beat_strobe |-> tx_send_invalid == tx_beat.error;
endproperty
a_inv: assert property (p_inv) else $error("invalid symbol request wrong");
property p_stb;
	tx_beat_strobe |=> !tx_beat_strobe;
endproperty
a_stb: assert property (p_stb) else $error("beat strobe longer than one cycle");
property p_bst;
	!tx_beat_strobe |-> $stable(tx_beat);
endproperty
a_bst: assert property (p_bst) else $error("beat changed without strobe");
c_rg: cover property (rgm && rx_take);
c_col: cover property (col);
c_inv: cover property (tx_beat_strobe && tx_send_invalid);
endmodule : pms_rx_status_pins_checker
bind pms_rx_status_pins pms_rx_status_pins_checker pms_rx_status_pins_checker_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode), .speed(speed),
	.full_duplex(full_duplex), .rx_symbol(rx_symbol), .rx_take(rx_take),
	.tx_beat(tx_beat), .tx_beat_strobe(tx_beat_strobe), .tx_send_invalid(tx_send_invalid),
	.rx_clk(rx_clk), .tx_clk(tx_clk), .receive_data_bit_four(receive_data_bit_four),
	.receive_data_bit_seven(receive_data_bit_seven), .rx_er(rx_er), .col(col), .crs(crs),
	.receive_valid_error_combined(receive_valid_error_combined));
`default_nettype wire

//--- tb/pms_mac_model.sv
// mac transmit side model: clock and control pins toward the phy
`timescale 1ns/1ns
`default_nettype none
module pms_mac_model (
	// control from the bench
	input wire logic run,
	input wire logic rgmii,
	input wire logic en,
	input wire logic er,
	// pins toward the phy
	output logic gtx_clk,
	output logic tx_en_ctrl,
	output logic tx_er
);
// collision and carrier sense never sampled
always
begin
	if (!run)
	begin
		// pulled-down pins idle low, clock stopped
		gtx_clk = 1'b0;
		tx_en_ctrl = 1'b0;
		tx_er = 1'b0;
		#40;
	end
	else
	begin
		gtx_clk = 1'b1;
		#60;
		// falling sample is enable xor error in rgmii, enable otherwise
		tx_en_ctrl = rgmii ? (en ^ er) : en;
		#20;
		gtx_clk = 1'b0;
		#60;
		// enable held for the rising sample
		tx_en_ctrl = en;
		tx_er = rgmii ? 1'b0 : er;
		#20;
	end
end
endmodule : pms_mac_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the mac-side receive status pins
`timescale 1ns/1ns
`default_nettype none
module tb;
import pms_pkg::*;
logic clk_sys, rst_n, full_duplex, rx_take, tx_beat_strobe, tx_send_invalid;
pms_mode_type mode;
pms_speed_type speed;
pms_rx_symbol_type rx_symbol;
pms_tx_beat_type tx_beat;
logic gtx_clk, tx_en_ctrl, tx_er, rx_clk, tx_clk, b4, b5, b6, b7, rx_ctl, rx_er, col, crs;
logic mac_run, mac_en, mac_er;
int n_mismatch;
int n_tests;
pms_rx_status_pins pms_rx_status_pins_inst (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode),
	.speed(speed), .full_duplex(full_duplex), .rx_symbol(rx_symbol), .rx_take(rx_take),
	.tx_beat(tx_beat), .tx_beat_strobe(tx_beat_strobe), .tx_send_invalid(tx_send_invalid),
	.gtx_clk(gtx_clk), .tx_en_ctrl(tx_en_ctrl), .tx_er(tx_er), .rx_clk(rx_clk), .tx_clk(tx_clk),
	.receive_data_bit_four(b4), .receive_data_bit_five(b5), .receive_data_bit_six(b6),
	.receive_data_bit_seven(b7), .receive_valid_error_combined(rx_ctl), .rx_er(rx_er),
	.col(col), .crs(crs));
pms_mac_model pms_mac_model_inst (.run(mac_run), .rgmii(mode == PMS_RGMII), .en(mac_en),
	.er(mac_er), .gtx_clk(gtx_clk), .tx_en_ctrl(tx_en_ctrl), .tx_er(tx_er));
initial
begin
	clk_sys = 1'b0;
	forever #10 clk_sys = ~clk_sys;
end
task close_out;
	$display("checks %0d mismatches %0d", n_tests, n_mismatch);
	if (n_mismatch == 0 && n_tests > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask : close_out
task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
	n_tests++;
	if (seen !== exp)
	begin
		n_mismatch++;
		$display("[ERR] %s expected %h seen %h", what, exp, seen);
	end
endtask : chk
task setup(input pms_mode_type m, input pms_speed_type s, input logic fd);
	@(negedge clk_sys);
	rst_n = 1'b0;
	mac_run = 1'b0;
	mode = m;
	speed = s;
	full_duplex = fd;
	repeat (16) @(negedge clk_sys);
	rst_n = 1'b1;
endtask : setup
// bounded wait for a take or a transmit strobe
task wait_sig(input logic on_take);
	int i;
	for (i = 0; i < 100; i++)
	begin
		@(negedge clk_sys);
		if ((on_take ? rx_take : tx_beat_strobe) === 1'b1)
			break;
	end
	if (i == 100)
	begin
		chk("handshake", 8'h00, 8'h01);
		close_out;
	end
endtask : wait_sig
task beat(input pms_rx_symbol_type sym);
	rx_symbol = sym;
	wait_sig(1'b1);
	@(negedge clk_sys);
endtask : beat
task t_gmii;
	pms_speed_type sp[3];
	sp = '{PMS_SPD_10, PMS_SPD_100, PMS_SPD_1000};
	foreach (sp[k])
	begin
		setup(PMS_GMII, sp[k], 1'b1);
		beat({1'b1, 1'b0, 1'b0, 8'ha5});
		chk("upper bits", 8'({b7, b6, b5, b4}), 8'h0a);
		chk("rx valid", 8'(rx_ctl), 8'h01);
		chk("rx clock", 8'(rx_clk), 8'h01);
		beat({1'b0, 1'b1, 1'b0, 8'h3c});
		chk("upper bits", 8'({b7, b6, b5, b4}), 8'h03);
		chk("rx error", 8'(rx_er), 8'h01);
		chk("rx valid", 8'(rx_ctl), 8'h00);
	end
	$display("gmii receive test done");
endtask : t_gmii
task t_mii;
	setup(PMS_MII, PMS_SPD_100, 1'b1);
	mac_en = 1'b1;
	mac_er = 1'b1;
	mac_run = 1'b1;
	beat({1'b1, 1'b0, 1'b0, 8'hf0});
	chk("upper bits", 8'({b7, b6, b5, b4}), 8'h00);
	chk("rx valid", 8'(rx_ctl), 8'h01);
	chk("tx clock", 8'(tx_clk), 8'h01);
	// error pin only settles late in the first transmit clock period
	repeat (12) wait_sig(1'b0);
	chk("tx beat", 8'(tx_beat), 8'h03);
	chk("tx invalid", 8'(tx_send_invalid), 8'h01);
	$display("mii test done");
endtask : t_mii
task t_rgmii;
	setup(PMS_RGMII, PMS_SPD_100, 1'b1);
	mac_en = 1'b1;
	mac_er = 1'b1;
	mac_run = 1'b1;
	beat({1'b1, 1'b1, 1'b1, 8'h00});
	chk("ctrl high", 8'(rx_ctl), 8'h01);
	@(negedge clk_sys);
	chk("ctrl low", 8'({rx_clk, rx_ctl}), 8'h00);
	chk("rx error", 8'(rx_er), 8'h00);
	chk("col crs", 8'({col, crs}), 8'h00);
	repeat (3) wait_sig(1'b0);
	chk("tx beat", 8'(tx_beat), 8'h03);
	chk("tx invalid", 8'(tx_send_invalid), 8'h01);
	mac_er = 1'b0;
	repeat (3) wait_sig(1'b0);
	chk("tx beat", 8'(tx_beat), 8'h02);
	$display("rgmii test done");
endtask : t_rgmii
task t_duplex;
	setup(PMS_GMII, PMS_SPD_100, 1'b0);
	mac_er = 1'b0;
	mac_run = 1'b1;
	repeat (3) wait_sig(1'b0);
	beat({1'b0, 1'b0, 1'b0, 8'h00});
	chk("col crs", 8'({col, crs}), 8'h01);
	beat({1'b0, 1'b0, 1'b1, 8'h00});
	chk("col crs", 8'({col, crs}), 8'h03);
	setup(PMS_GMII, PMS_SPD_100, 1'b1);
	mac_run = 1'b1;
	repeat (3) wait_sig(1'b0);
	beat({1'b0, 1'b0, 1'b0, 8'h00});
	chk("col crs", 8'({col, crs}), 8'h00);
	beat({1'b0, 1'b0, 1'b1, 8'h00});
	chk("col crs", 8'({col, crs}), 8'h01);
	$display("duplex test done");
endtask : t_duplex
initial
begin
	n_mismatch = 0;
	n_tests = 0;
	rst_n = 1'b0;
	mode = PMS_GMII;
	speed = PMS_SPD_100;
	full_duplex = 1'b1;
	rx_symbol = '0;
	mac_run = 1'b0;
	mac_en = 1'b0;
	mac_er = 1'b0;
	t_gmii;
	t_mii;
	t_rgmii;
	t_duplex;
	close_out;
end
endmodule : tb
`default_nettype wire
